//--- mide_consts.vh
// shared constants for the inc/dec/move/jump/halt execution block
`ifndef MIDE_CONSTS_VH
`define MIDE_CONSTS_VH
// operation codes presented on op_in (block-local encoding)
`define MIDE_OP_NONE      4'h0
`define MIDE_OP_SUB_MEM   4'h1
`define MIDE_OP_SUB_ACC   4'h2
`define MIDE_OP_ADD_MEM   4'h3
`define MIDE_OP_ADD_ACC   4'h4
`define MIDE_OP_BRANCH    4'h5
`define MIDE_OP_MOV_M2A   4'h6
`define MIDE_OP_MOV_IMM   4'h7
`define MIDE_OP_MOV_A2M   4'h8
`define MIDE_OP_SLEEP     4'h9
// reset values
`define MIDE_ACC_RST      8'h00
`define MIDE_PC_RST       11'h000
`define MIDE_FLAG_RST     1'b0
// cycle counts
`define MIDE_BRANCH_CYC   2
`define MIDE_WDT_MAX      16'hFFFF
`define MIDE_PSC_MAX      8'hFF
`endif

//--- mide_dmem.v
// data memory with one synchronous write port and combinational read
`timescale 1ns/1ps
module mide_dmem #(
  parameter AW = 7,
  parameter DW = 8
) (
  input  wire          mclk_in,
  input  wire          we_in,
  input  wire [AW-1:0] addr_in,
  input  wire [DW-1:0] wdata_in,
  output wire [DW-1:0] rdata_out
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // contents are never reset, so they survive sleep and core reset alike
  always @(posedge mclk_in)
  begin
    if (we_in)
    begin
      mem_r[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem_r[addr_in];
endmodule

//--- mide_wdt.v
// watchdog counter with prescaler, cleared on sleep entry
`timescale 1ns/1ps
`include "mide_consts.vh"
module mide_wdt (
  input  wire mclk_in,
  input  wire rst_b_in,
  input  wire clr_in,
  output reg  expire_out
);
  reg [7:0]  psc_r;
  reg [15:0] cnt_r;
  wire       tick;

  assign tick = (psc_r == `MIDE_PSC_MAX);

  always @(posedge mclk_in)
  begin
    if (!rst_b_in || clr_in)
    begin
      psc_r      <= 8'h00;
      cnt_r      <= 16'h0000;
      expire_out <= 1'b0;
    end
    else
    begin
      psc_r      <= psc_r + 8'h01;
      expire_out <= tick && (cnt_r == `MIDE_WDT_MAX);
      if (tick)
      begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule

//--- mide_exec.v
// execution unit for inc/dec, moves, jump and sleep entry
//
// Functional notes
// - decrement memory, write back, update zero
// - decrement into accumulator, memory unchanged
// - sleep halts execution and gates clock
// - sleep clears watchdog count and prescaler
// - sleep sets sleep flag, clears expiry
// - increment memory, write back, update zero
// - increment into accumulator, memory unchanged
// - jump loads address, flags untouched
// - jump takes two cycles, one dummy
// - copy memory into accumulator, flags kept
// - copy immediate into accumulator, flags kept
// - copy accumulator into memory, flags kept
`timescale 1ns/1ps
`include "mide_consts.vh"
module mide_exec #(
  parameter AW  = 7,
  parameter PCW = 11
) (
  input  wire           mclk_in,
  input  wire           rst_b_in,
  input  wire           valid_in,
  input  wire [3:0]     op_in,
  input  wire [AW-1:0]  addr_in,
  input  wire [7:0]     imm_in,
  input  wire [PCW-1:0] target_in,
  input  wire           wake_in,
  output reg            ready_out,
  output reg  [7:0]     acc_out,
  output reg  [PCW-1:0] pc_out,
  output reg            zero_flag_out,
  output reg            sleep_entry_flag_out,
  output reg            watchdog_expiry_flag_out,
  output reg            clk_gate_out,
  output reg            halted_out
);
////////////////////////////////////////////////////////////////////////////
  localparam ST_RUN   = 3'b001;
  localparam ST_DUMMY = 3'b010;
  localparam ST_SLEEP = 3'b100;

  reg  [2:0]     state_r;
  reg  [2:0]     state_nxt;
  reg  [7:0]     acc_nxt;
  reg  [PCW-1:0] pc_nxt;
  reg            zero_nxt;
  reg            mem_we;
  reg  [7:0]     mem_wdata;
  reg            wdt_clr;
  reg            sleep_set;
  wire [7:0]     mem_rdata;
  wire           wdt_expire;
  wire [7:0]     plus_one;
  wire [7:0]     minus_one;
  wire           take;

  // 8-bit wrap is inherent to the width
  assign plus_one  = mem_rdata + 8'h01;
  assign minus_one = mem_rdata - 8'h01;
  // ready_out gates the first edge after reset, when the bus may not be valid
  assign take      = valid_in && ready_out && (state_r == ST_RUN);

////////////////////////////////////////////////////////////////////////////
  mide_dmem #(
    .AW (AW),
    .DW (8)
  ) u_dmem (
    .mclk_in   (mclk_in),
    .we_in     (mem_we),
    .addr_in   (addr_in),
    .wdata_in  (mem_wdata),
    .rdata_out (mem_rdata)
  );

  mide_wdt u_wdt (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .clr_in     (wdt_clr),
    .expire_out (wdt_expire)
  );

////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    state_nxt = state_r;
    acc_nxt   = acc_out;
    pc_nxt    = pc_out;
    zero_nxt  = zero_flag_out;
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    wdt_clr   = 1'b0;
    sleep_set = 1'b0;
    case (state_r)
      ST_RUN:
      begin
        if (take)
        begin
          // every op here but the jump and the sleep retires in this one cycle
          pc_nxt = pc_out + {{(PCW-1){1'b0}}, 1'b1};
          case (op_in)
            `MIDE_OP_SUB_MEM:
            begin
              mem_we    = 1'b1;
              mem_wdata = minus_one;
              zero_nxt  = (minus_one == 8'h00);
            end
            `MIDE_OP_SUB_ACC:
            begin
              acc_nxt  = minus_one;
              zero_nxt = (minus_one == 8'h00);
            end
            `MIDE_OP_ADD_MEM:
            begin
              mem_we    = 1'b1;
              mem_wdata = plus_one;
              zero_nxt  = (plus_one == 8'h00);
            end
            `MIDE_OP_ADD_ACC:
            begin
              acc_nxt  = plus_one;
              zero_nxt = (plus_one == 8'h00);
            end
            `MIDE_OP_BRANCH:
            begin
              pc_nxt    = target_in;
              state_nxt = ST_DUMMY;
            end
            `MIDE_OP_MOV_M2A:
            begin
              acc_nxt = mem_rdata;
            end
            `MIDE_OP_MOV_IMM:
            begin
              acc_nxt = imm_in;
            end
            `MIDE_OP_MOV_A2M:
            begin
              mem_we    = 1'b1;
              mem_wdata = acc_out;
            end
            `MIDE_OP_SLEEP:
            begin
              wdt_clr   = 1'b1;
              sleep_set = 1'b1;
              state_nxt = ST_SLEEP;
            end
            default:
            begin
              pc_nxt = pc_out + {{(PCW-1){1'b0}}, 1'b1};
            end
          endcase
        end
      end
      ST_DUMMY:
      begin
        // dummy cycle: nothing is taken while the new address settles
        state_nxt = ST_RUN;
      end
      ST_SLEEP:
      begin
        // watchdog held cleared until wake_in returns the unit to run
        wdt_clr = 1'b1;
        if (wake_in)
        begin
          state_nxt = ST_RUN;
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      state_r                  <= ST_RUN;
      acc_out                  <= `MIDE_ACC_RST;
      pc_out                   <= `MIDE_PC_RST;
      zero_flag_out            <= `MIDE_FLAG_RST;
      sleep_entry_flag_out     <= `MIDE_FLAG_RST;
      watchdog_expiry_flag_out <= `MIDE_FLAG_RST;
      ready_out                <= 1'b0;
      clk_gate_out             <= 1'b0;
      halted_out               <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      acc_out       <= acc_nxt;
      pc_out        <= pc_nxt;
      zero_flag_out <= zero_nxt;
      ready_out     <= (state_nxt == ST_RUN);
      halted_out    <= (state_nxt == ST_SLEEP);
      clk_gate_out  <= (state_nxt == ST_SLEEP);
      if (sleep_set)
      begin
        sleep_entry_flag_out     <= 1'b1;
        watchdog_expiry_flag_out <= 1'b0;
      end
      else if (wdt_expire)
      begin
        watchdog_expiry_flag_out <= 1'b1;
      end
    end
  end
endmodule

//--- mide_exec_monitor.sv
// port-level assertions for the execution unit
`timescale 1ns/1ps
`include "mide_consts.vh"
module mide_exec_monitor #(
  parameter AW  = 7,
  parameter PCW = 11
) (
  input wire           mclk_in,
  input wire           rst_b_in,
  input wire           valid_in,
  input wire [3:0]     op_in,
  input wire [AW-1:0]  addr_in,
  input wire [7:0]     imm_in,
  input wire [PCW-1:0] target_in,
  input wire           wake_in,
  input wire           ready_out,
  input wire [7:0]     acc_out,
  input wire [PCW-1:0] pc_out,
  input wire           zero_flag_out,
  input wire           sleep_entry_flag_out,
  input wire           watchdog_expiry_flag_out,
  input wire           clk_gate_out,
  input wire           halted_out
);
  wire tk = valid_in && ready_out;
  wire br = tk && (op_in == `MIDE_OP_BRANCH);
  wire sl = tk && (op_in == `MIDE_OP_SLEEP);
  wire im = tk && (op_in == `MIDE_OP_MOV_IMM);
  wire st = tk && (op_in == `MIDE_OP_MOV_A2M);
  wire ac = tk && (op_in == `MIDE_OP_SUB_ACC || op_in == `MIDE_OP_ADD_ACC);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_branch_dummy:
  assert property (br |=> !ready_out ##1 ready_out) else $error("no dummy");
  a_branch_target:
  assert property (br |=> pc_out == $past(target_in) && $stable(zero_flag_out))
    else $error("branch target wrong");
  a_sleep_flags:
  assert property (sl |=> sleep_entry_flag_out && !watchdog_expiry_flag_out)
    else $error("sleep flags wrong");
  a_sleep_halt:
  assert property (sl |=> halted_out && clk_gate_out && !ready_out)
    else $error("sleep not halted");
  a_sleep_hold:
  assert property (halted_out && !wake_in |=> $stable(acc_out) && $stable(pc_out))
    else $error("state moved in sleep");
  a_imm_load:
  assert property (im |=> acc_out == $past(imm_in) && $stable(zero_flag_out))
    else $error("immediate load wrong");
  a_acc_zero:
  assert property (ac |=> zero_flag_out == (acc_out == 8'h00))
    else $error("zero flag wrong");
  a_store_keeps:
  assert property (st |=> $stable(acc_out) && $stable(zero_flag_out))
    else $error("store changed state");
  a_one_cycle:
  assert property (tk && !br && !sl |=> ready_out && pc_out == $past(pc_out) + 1'b1)
    else $error("single cycle broken");
endmodule

//--- tb_mcu_incdec_move_jump_halt_exec.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`include "mide_consts.vh"
module tb_mcu_incdec_move_jump_halt_exec;
  reg         mclk_in   = 1'b0;
  reg         rst_b_in  = 1'b0;
  reg         valid_in  = 1'b0;
  reg  [3:0]  op_in     = 4'h0;
  reg  [6:0]  addr_in   = 7'h00;
  reg  [7:0]  imm_in    = 8'h00;
  reg  [10:0] target_in = 11'h000;
  reg         wake_in   = 1'b0;
  wire        rdy, zf, sf, ef, gt, hl;
  wire [7:0]  acc;
  wire [10:0] pc;
  reg  [27:0] rows [0:7];
  integer     failures = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  mide_exec mide_exec_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .valid_in(valid_in), .op_in(op_in), .addr_in(addr_in), .imm_in(imm_in),
    .target_in(target_in), .wake_in(wake_in), .ready_out(rdy),
    .acc_out(acc), .pc_out(pc), .zero_flag_out(zf),
    .sleep_entry_flag_out(sf), .watchdog_expiry_flag_out(ef),
    .clk_gate_out(gt), .halted_out(hl));
  always #12.5 mclk_in = ~mclk_in;
  task end_sim;
  begin
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input string n, input [10:0] e, input [10:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task step;
  begin
    @(posedge mclk_in);
    #1;
  end
  endtask
  // a hang is cut well beyond the few dozen cycles the tests need
  always @(posedge mclk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      failures = failures + 1;
      end_sim;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    // op, address, immediate, expected accumulator, expected zero flag
    rows[0] = {`MIDE_OP_MOV_IMM, 7'h05, 8'h00, 8'h00, 1'b0};
    rows[1] = {`MIDE_OP_MOV_A2M, 7'h05, 8'h00, 8'h00, 1'b0};
    rows[2] = {`MIDE_OP_SUB_MEM, 7'h05, 8'h00, 8'h00, 1'b0};
    rows[3] = {`MIDE_OP_MOV_M2A, 7'h05, 8'h00, 8'hFF, 1'b0};
    rows[4] = {`MIDE_OP_ADD_ACC, 7'h05, 8'h00, 8'h00, 1'b1};
    rows[5] = {`MIDE_OP_ADD_MEM, 7'h05, 8'h00, 8'h00, 1'b1};
    rows[6] = {`MIDE_OP_SUB_ACC, 7'h05, 8'h00, 8'hFF, 1'b0};
    rows[7] = {`MIDE_OP_MOV_M2A, 7'h05, 8'h00, 8'h00, 1'b0};
    repeat (4) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    step;
    valid_in = 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      {op_in, addr_in, imm_in} = rows[i][27:9];
      step;
      chk("acc", rows[i][8:1], acc);
      chk("zero", rows[i][0], zf);
      chk("ready", 1'b1, rdy);
    end
    chk("pc", 11'h008, pc);
    op_in = `MIDE_OP_BRANCH;
    target_in = 11'h5A3;
    step;
    op_in = `MIDE_OP_MOV_IMM;
    imm_in = 8'h3C;
    chk("pc", 11'h5A3, pc);
    chk("ready", 1'b0, rdy);
    step;
    chk("acc", 8'h00, acc);
    step;
    chk("acc", 8'h3C, acc);
    chk("pc", 11'h5A4, pc);
    op_in = `MIDE_OP_SLEEP;
    step;
    op_in = `MIDE_OP_MOV_IMM;
    imm_in = 8'h77;
    chk("sleep", 1'b1, sf);
    chk("expiry", 1'b0, ef);
    chk("gate", 1'b1, gt);
    repeat (3) step;
    chk("acc", 8'h3C, acc);
    chk("halted", 1'b1, hl);
    wake_in = 1'b1;
    step;
    wake_in = 1'b0;
    step;
    chk("acc", 8'h77, acc);
    chk("sleep", 1'b1, sf);
    // mid-run reset with an instruction left pending on the bus
    imm_in = 8'h5E;
    rst_b_in = 1'b0;
    step;
    chk("acc", 8'h00, acc);
    chk("pc", 11'h000, pc);
    chk("sleep", 1'b0, sf);
    chk("ready", 1'b0, rdy);
    rst_b_in = 1'b1;
    step;
    chk("acc", 8'h00, acc);
    chk("ready", 1'b1, rdy);
    step;
    chk("acc", 8'h5E, acc);
    chk("pc", 11'h001, pc);
    valid_in = 1'b0;
    end_sim;
  end
endmodule
bind mide_exec mide_exec_monitor #(.AW(AW), .PCW(PCW)) mon_i (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .valid_in(valid_in),
  .op_in(op_in), .addr_in(addr_in), .imm_in(imm_in), .target_in(target_in),
  .wake_in(wake_in), .ready_out(ready_out), .acc_out(acc_out),
  .pc_out(pc_out), .zero_flag_out(zero_flag_out),
  .sleep_entry_flag_out(sleep_entry_flag_out),
  .watchdog_expiry_flag_out(watchdog_expiry_flag_out),
  .clk_gate_out(clk_gate_out), .halted_out(halted_out));
